//--- rtl/supply_loss_and_wake_report.v
// Purpose: Supply supervision, fail mode entry and wake state report
// Assumes: Supply comparator levels arrive synchronous to clk
// Notes:   Power-off clears retained state through a synchronous clear
`timescale 1ns/1ps
`include "supply_loss_defs.vh"

// Behaviour
// [R1] No serial readback without logic supply
// [R2] Report wake on clock pin during reset
// [R3] Drive clock pin high when awake
// [R4] Sleep or reset wake: clock pin undriven
// [R5] Both supplies low: power off, clear all
// [R6] Battery loss: retain, main off, aux configured
// [R7] Status readback while logic supply in range
// [R8] No wake report without battery supply
// [R9] Logic supply loss means watchdog timeout
// [R10] Ground loss switches main outputs off
// [R11] Clock fail: fallback sense sync period
// [R12] Communication error enters fail mode
// [R13] Failure flag set while in fail mode
// [R14] Stay off until both supplies return
module supply_loss_and_wake_report #(
  parameter SYNC_PERIOD_CYC = `SYNC_NOM_CYC
) (
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire                 bat_above_por,
  input  wire                 vcc_above_por,
  input  wire                 vcc_in_range,
  input  wire                 gnd_ok,
  input  wire                 awake,
  input  wire                 wake_by_reset,
  input  wire                 wake_reset_n_pin,
  input  wire                 spi_error,
  input  wire                 fail_exit,
  input  wire                 pwm_clk_fail,
  input  wire                 pwm_sync_pulse,
  input  wire [`MAIN_W-1:0]   main_request,
  input  wire                 aux_request,
  input  wire                 readback_req,
  output reg  [`MAIN_W-1:0]   main_switch_outputs,
  output reg                  aux_driver_output,
  output reg                  clk_pin_out,
  output reg                  clk_pin_oe,
  output reg                  readback_enable,
  output reg                  serial_failure_flag,
  output reg                  fail_mode,
  output reg                  regs_clear,
  output reg                  sense_sync_output,
  output reg  [`MODE_W-1:0]   supply_mode
);

  // ----------------------------------------------------------------
  // Supply mode decision
  // ----------------------------------------------------------------
  reg [`MODE_W-1:0] mode_nxt;

  // [R5] Both supplies lost
  // [R14] Hold until both return
  always @* begin
    mode_nxt = supply_mode;
    case (supply_mode)
      `MODE_POWER_OFF: begin
        if (bat_above_por && vcc_above_por)
          mode_nxt = `MODE_NORMAL;
      end
      default: begin
        if (!bat_above_por && !vcc_above_por)
          mode_nxt = `MODE_POWER_OFF;
        // [R6] Battery loss retains
        else if (!bat_above_por)
          mode_nxt = `MODE_RETAIN;
        // [R9] Logic supply timeout
        else if (!vcc_above_por)
          mode_nxt = `MODE_WD_TIMEOUT;
        else
          mode_nxt = `MODE_NORMAL;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_mode <= `MODE_POWER_OFF;
    end else begin
      supply_mode <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fail mode and failure flag
  // ----------------------------------------------------------------
  wire comm_error = spi_error || (supply_mode == `MODE_WD_TIMEOUT);

  // [R12] Error enters fail
  // [R13] Flag held in fail
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_mode           <= 1'b0;
      serial_failure_flag <= 1'b0;
    end else if (supply_mode == `MODE_POWER_OFF) begin
      fail_mode           <= 1'b0;
      serial_failure_flag <= 1'b0;
    end else if (comm_error) begin
      fail_mode           <= 1'b1;
      serial_failure_flag <= 1'b1;
    end else if (fail_exit) begin
      fail_mode           <= 1'b0;
      serial_failure_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and register clear
  // ----------------------------------------------------------------
  wire main_allowed = (supply_mode == `MODE_NORMAL) ||
                      (supply_mode == `MODE_WD_TIMEOUT);

  // [R10] Ground loss off
  // [R6] Aux per configuration
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_switch_outputs <= `MAIN_OFF;
      aux_driver_output   <= 1'b0;
      regs_clear          <= 1'b1;
    end else begin
      regs_clear <= (mode_nxt == `MODE_POWER_OFF);
      if (main_allowed && gnd_ok && mode_nxt != `MODE_POWER_OFF &&
          mode_nxt != `MODE_RETAIN)
        main_switch_outputs <= main_request;
      else
        main_switch_outputs <= `MAIN_OFF;
      aux_driver_output <= gnd_ok && vcc_above_por &&
                           (mode_nxt != `MODE_POWER_OFF) && aux_request;
    end
  end

  // ----------------------------------------------------------------
  // Serial readback gate
  // ----------------------------------------------------------------
  // [R1] Readback needs logic supply
  // [R7] Status while in range
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readback_enable <= 1'b0;
    end else begin
      readback_enable <= readback_req && vcc_above_por && vcc_in_range &&
                         (mode_nxt != `MODE_POWER_OFF);
    end
  end

  // ----------------------------------------------------------------
  // Wake state report on shared clock pin
  // ----------------------------------------------------------------
  // [R2] Report during reset low
  // [R3] Drive high awake
  // [R4] Else input only
  // [R8] No report on battery loss
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_pin_out <= 1'b0;
      clk_pin_oe  <= 1'b0;
    end else begin
      clk_pin_out <= 1'b1;
      clk_pin_oe  <= !wake_reset_n_pin && awake && !wake_by_reset &&
                     bat_above_por && (mode_nxt == `MODE_NORMAL ||
                     mode_nxt == `MODE_WD_TIMEOUT);
    end
  end

  // ----------------------------------------------------------------
  // Current sense synchronisation
  // ----------------------------------------------------------------
  reg [`SYNC_CNT_W-1:0] sync_cnt_r;
  wire                  sync_wrap = (sync_cnt_r ==
                                     SYNC_PERIOD_CYC[`SYNC_CNT_W-1:0] - 1'b1);

  // [R11] Fallback sync period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_cnt_r        <= {`SYNC_CNT_W{1'b0}};
      sense_sync_output <= 1'b0;
    end else if (!pwm_clk_fail) begin
      sync_cnt_r        <= {`SYNC_CNT_W{1'b0}};
      sense_sync_output <= pwm_sync_pulse;
    end else if (sync_wrap) begin
      sync_cnt_r        <= {`SYNC_CNT_W{1'b0}};
      sense_sync_output <= 1'b1;
    end else begin
      sync_cnt_r        <= sync_cnt_r + 1'b1;
      sense_sync_output <= 1'b0;
    end
  end

endmodule // supply_loss_and_wake_report

//--- rtl/supply_loss_defs.vh
// Purpose: Constants for the supply loss and wake report block
// Assumes: 20 MHz system clock
// Notes:   Times are in microseconds; cycle counts derive from them
`ifndef SUPPLY_LOSS_DEFS_VH
`define SUPPLY_LOSS_DEFS_VH
`define CLK_MHZ            20
`define SYNC_NOM_US        6500
`define SYNC_MIN_US        4800
`define SYNC_MAX_US        8200
`define SYNC_NOM_CYC       (`SYNC_NOM_US * `CLK_MHZ)
`define SYNC_CNT_W         18
`define MAIN_W             4
`define MAIN_OFF           4'h0
`define MODE_W             2
`define MODE_POWER_OFF     2'h0
`define MODE_NORMAL        2'h1
`define MODE_RETAIN        2'h2
`define MODE_WD_TIMEOUT    2'h3
`endif

//--- tb/host_mcu_model.sv
// Purpose: Host stand-in. Assumes: falling edge drive. Notes: rare errors
`timescale 1ns/1ps
module host_mcu_model (
  input  wire       clk,
  output reg  [3:0] main_request,
  output reg        aux_request, readback_req, wake_reset_n_pin, spi_error, fail_exit
);
  // Random requests, errors and exits
  initial {main_request, aux_request, readback_req, wake_reset_n_pin, spi_error, fail_exit} = 9'h000;
  always @(negedge clk) begin
    {main_request, aux_request, readback_req, wake_reset_n_pin} <= 7'($urandom);
    spi_error <= $urandom % 16 == 0;
    fail_exit <= $urandom % 8 == 0;
  end
endmodule // host_mcu_model

//--- tb/supply_loss_and_wake_report_assertions.sv
// Purpose: Port checks. Assumes: one clock. Notes: outputs lag inputs one edge
`timescale 1ns/1ps
module supply_loss_checker (
  input wire       clk, rst_n, bat_above_por, vcc_above_por, vcc_in_range, gnd_ok, awake,
  input wire       wake_by_reset, wake_reset_n_pin, spi_error, fail_exit, clk_pin_out,
  input wire       clk_pin_oe, readback_enable, serial_failure_flag, fail_mode,
  input wire [3:0] main_switch_outputs,
  input wire [1:0] supply_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  pin_drive_a: assert property (clk_pin_oe |-> clk_pin_out && $past(awake &&
    !wake_by_reset && !wake_reset_n_pin && bat_above_por)) else $error("bad pin drive");
  readback_supply_a: assert property (readback_enable |-> supply_mode != 0 &&
    $past(vcc_above_por && vcc_in_range)) else $error("bad readback");
  retain_entry_a: assert property ($past(!bat_above_por && vcc_above_por &&
    supply_mode % 3 != 0) |-> supply_mode == 2 && main_switch_outputs == 0) else $error("no retain");
  wd_entry_a: assert property ($past(bat_above_por && !vcc_above_por &&
    supply_mode != 0) |-> supply_mode == 3) else $error("no timeout");
  wd_fail_a: assert property (supply_mode == 3 && $past(supply_mode) == 3 |->
    fail_mode && serial_failure_flag) else $error("timeout not failing");
  error_fail_a: assert property ($past(spi_error && supply_mode == 1 &&
    bat_above_por && vcc_above_por) |-> fail_mode && serial_failure_flag) else $error("no fail");
  flag_hold_a: assert property ($past(serial_failure_flag && !fail_exit &&
    supply_mode != 0 && (bat_above_por || vcc_above_por)) |-> serial_failure_flag)
    else $error("flag lost");
  ground_off_a: assert property (!$past(gnd_ok) |-> main_switch_outputs == 0)
    else $error("outputs on");
  cover property (supply_mode == 2);
  cover property (supply_mode == 3 ##1 fail_mode);
  cover property (clk_pin_oe);
endmodule // supply_loss_checker
bind supply_loss_and_wake_report supply_loss_checker i_supply_loss_checker (.*);

//--- tb/supply_loss_and_wake_report_tb.sv
// Purpose: Random supply bench. Assumes: 50 ns clock. Notes: sync period 20
`timescale 1ns/1ps
module supply_loss_and_wake_report_tb;
  reg clk = 0, rst_n = 0, bat_above_por = 0, vcc_above_por = 0, vcc_in_range = 0, gnd_ok = 1;
  reg awake = 0, wake_by_reset = 0, pwm_clk_fail = 0, pwm_sync_pulse = 0;
  wire [3:0] main_request, main_switch_outputs;
  wire [1:0] supply_mode;
  wire aux_request, readback_req, wake_reset_n_pin, spi_error, fail_exit, fail_mode, regs_clear;
  wire aux_driver_output, clk_pin_out, clk_pin_oe, readback_enable, serial_failure_flag;
  wire sense_sync_output;
  integer n_fail = 0, n_compared = 0, cyc = 0, n = 0, m = 0, e = 0;
  integer a = 0, r = 1, q = 0, s = 0;
  host_mcu_model i_host_mcu_model (.*);
  supply_loss_and_wake_report #(.SYNC_PERIOD_CYC(20)) i_supply_loss_and_wake_report (.*);
  // Next mode from supply levels
  wire b = bat_above_por, v = vcc_above_por;
  wire [1:0] x = m == 0 ? {1'b0, b & v} : !b && !v ? 2'h0 : !b ? 2'h2 : !v ? 2'h3 : 2'h1;
  task chk(input ok);
    n_compared = n_compared + 1;
    if (!ok) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  // Model of mode and outputs, cycle ceiling
  always @(posedge clk) begin
    m <= rst_n ? x : 0;
    // Main outputs need the current mode to allow them as well
    e <= !rst_n || !gnd_ok || !x[0] || m % 2 == 0 ? 0 : x == 1 ? 16 + main_request : -1;
    a <= rst_n && gnd_ok && v && x != 0 && aux_request;
    r <= !rst_n || x == 0;
    q <= rst_n && readback_req && vcc_in_range && v && x != 0;
    s <= rst_n && !pwm_clk_fail && pwm_sync_pulse;
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  // Compare once outputs settle
  always @(negedge clk) if (rst_n) begin
    chk(supply_mode === m[1:0]);
    if (e >= 0 && (e < 16 || fail_mode === 1'b0)) chk(main_switch_outputs === e[3:0]);
    chk(aux_driver_output === a[0]);
    chk(regs_clear === r[0]);
    chk(readback_enable === q[0]);
    if (!pwm_clk_fail) chk(sense_sync_output === s[0]);
  end
  initial begin
    void'($urandom(76624));
    repeat (20) @(negedge clk);
    rst_n = 1;
    repeat (2000) begin
      @(negedge clk);
      if ($urandom % 8 == 0) {bat_above_por, vcc_above_por} = 2'($urandom);
      {vcc_in_range, awake, wake_by_reset, pwm_sync_pulse} = 4'($urandom);
      gnd_ok = $urandom % 16 != 0;
      rst_n = cyc < 1200 || cyc > 1203;
    end
    {pwm_clk_fail, pwm_sync_pulse, bat_above_por, vcc_above_por} = 4'hb;
    repeat (400) begin
      @(posedge clk);
      #1 n = n + sense_sync_output;
    end
    chk(n >= 19 && n <= 21);
    give_verdict;
  end
endmodule // supply_loss_and_wake_report_tb
